/* rtl/asq_defs.vh */
// constants for the adc slot sequencer
`ifndef ASQ_DEFS_VH
`define ASQ_DEFS_VH

// byte addresses of the slot map
`define ASQ_ADDR_LEN_S10    16'h2100
`define ASQ_ADDR_S8_S9      16'h2101
`define ASQ_ADDR_S6_S7      16'h2102
`define ASQ_ADDR_S4_S5      16'h2103
`define ASQ_ADDR_S2_S3      16'h2104
`define ASQ_ADDR_S0_S1      16'h2105
// read-only sequencer status
`define ASQ_ADDR_STATUS     16'h2106

// nibble fields inside each map byte
`define ASQ_LO_MSB          3
`define ASQ_LO_LSB          0
`define ASQ_HI_MSB          7
`define ASQ_HI_LSB          4

// reset values
`define ASQ_RST_BYTE        8'h00
`define ASQ_RST_NIB         4'h0
`define ASQ_RD_ZERO         8'h00

// frame limits
`define ASQ_MAX_SLOTS       4'hb
`define ASQ_SLOT_ONE        4'h1

// slot dwell time and clock period in ns
`define ASQ_SLOT_NS         1000
`define ASQ_CLK_NS          5
`define ASQ_SLOT_CYC ((`ASQ_SLOT_NS + `ASQ_CLK_NS - 1) / `ASQ_CLK_NS)

`endif

/* rtl/asq_slot_reg.v */
// one byte-wide register of the slot map
`timescale 1ns/1ps
`default_nettype none
`include "asq_defs.vh"

module asq_slot_reg
#(
    parameter [15:0] ADDR = 16'h0000
)
(
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire [15:0] addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    output wire        hit_o,
    output wire [7:0]  q_o
);

    reg  [7:0] byte_ff;

    assign hit_o = (addr_i == ADDR);
    assign q_o   = byte_ff;

    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            byte_ff <= `ASQ_RST_BYTE;
        end
        else if (wr_i && hit_o)
        begin
            byte_ff <= wdata_i;
        end
    end

endmodule // asq_slot_reg

`default_nettype wire

/* rtl/asq_slot_timer.v */
// slot dwell divider: one-cycle tick at the end of each slot
`timescale 1ns/1ps
`default_nettype none
`include "asq_defs.vh"

module asq_slot_timer
(
    input  wire clk_sys_i,
    input  wire rst_n_i,
    input  wire run_i,
    output wire tick_o
);

    localparam integer     CYC    = `ASQ_SLOT_CYC;
    localparam integer     LAST_I = CYC - 1;
    localparam [15:0]      LAST   = LAST_I[15:0];
    localparam [15:0]      ZERO = 16'h0000;
    localparam [15:0]      ONE  = 16'h0001;

    reg  [15:0] cnt_ff;
    reg  [15:0] nxt_cnt;

    assign tick_o = run_i && (cnt_ff == LAST);

    always @*
    begin
        nxt_cnt = cnt_ff;
        if (!run_i || tick_o)
        begin
            nxt_cnt = ZERO;
        end
        else
        begin
            nxt_cnt = cnt_ff + ONE;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= ZERO;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule // asq_slot_timer

`default_nettype wire

/* rtl/asq_sequencer.v */
// adc input multiplexer slot sequencer with its byte register map
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "asq_defs.vh"

module asq_sequencer
(
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire [15:0] addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output wire [7:0]  rdata_o,
    output wire [3:0]  mux_sel_o,
    output wire [3:0]  slot_o,
    output wire        slot_start_o,
    output wire        frame_start_o,
    output wire        busy_o
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN  = 2'h1;

    // map bytes, lowest address first
    wire [7:0]  len_s10;
    wire [7:0]  s8_s9;
    wire [7:0]  s6_s7;
    wire [7:0]  s4_s5;
    wire [7:0]  s2_s3;
    wire [7:0]  s0_s1;
    wire        hit_len_s10;
    wire        hit_s8_s9;
    wire        hit_s6_s7;
    wire        hit_s4_s5;
    wire        hit_s2_s3;
    wire        hit_s0_s1;
    wire        hit_status;
    wire        slot_tick;

    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [3:0]  slot_ff;
    reg  [3:0]  nxt_slot;
    reg  [3:0]  len_ff;
    reg  [3:0]  nxt_len;
    reg  [3:0]  sel_ff;
    reg  [3:0]  nxt_sel;
    reg         slot_start_ff;
    reg         nxt_slot_start;
    reg         frame_start_ff;
    reg         nxt_frame_start;
    reg  [7:0]  rdata_ff;
    reg  [7:0]  nxt_rdata;
    reg         busy_ff;
    reg  [3:0]  cfg_len;
    reg  [3:0]  eff_len;

    // slot map: each byte carries two selectors, except the first, which holds the frame length and the slot 10 selector
    asq_slot_reg #(.ADDR(`ASQ_ADDR_LEN_S10)) u_len_s10
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .addr_i    (addr_i),
        .wdata_i   (wdata_i),
        .wr_i      (wr_i),
        .hit_o     (hit_len_s10),
        .q_o       (len_s10)
    );

    asq_slot_reg #(.ADDR(`ASQ_ADDR_S8_S9)) u_s8_s9
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .addr_i    (addr_i),
        .wdata_i   (wdata_i),
        .wr_i      (wr_i),
        .hit_o     (hit_s8_s9),
        .q_o       (s8_s9)
    );

    asq_slot_reg #(.ADDR(`ASQ_ADDR_S6_S7)) u_s6_s7
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .addr_i    (addr_i),
        .wdata_i   (wdata_i),
        .wr_i      (wr_i),
        .hit_o     (hit_s6_s7),
        .q_o       (s6_s7)
    );

    asq_slot_reg #(.ADDR(`ASQ_ADDR_S4_S5)) u_s4_s5
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .addr_i    (addr_i),
        .wdata_i   (wdata_i),
        .wr_i      (wr_i),
        .hit_o     (hit_s4_s5),
        .q_o       (s4_s5)
    );

    asq_slot_reg #(.ADDR(`ASQ_ADDR_S2_S3)) u_s2_s3
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .addr_i    (addr_i),
        .wdata_i   (wdata_i),
        .wr_i      (wr_i),
        .hit_o     (hit_s2_s3),
        .q_o       (s2_s3)
    );

    asq_slot_reg #(.ADDR(`ASQ_ADDR_S0_S1)) u_s0_s1
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .addr_i    (addr_i),
        .wdata_i   (wdata_i),
        .wr_i      (wr_i),
        .hit_o     (hit_s0_s1),
        .q_o       (s0_s1)
    );

    assign hit_status = (addr_i == `ASQ_ADDR_STATUS);

    asq_slot_timer u_timer
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .run_i     (state_ff == ST_RUN),
        .tick_o    (slot_tick)
    );

    // frame length as programmed, then limited to the slots that exist
    always @*
    begin
        cfg_len = len_s10[`ASQ_HI_MSB:`ASQ_HI_LSB];
        eff_len = cfg_len;
        if (cfg_len > `ASQ_MAX_SLOTS)
        begin
            eff_len = `ASQ_MAX_SLOTS;
        end
    end

    // selector lookup for the slot about to be driven
    always @*
    begin
        case (nxt_slot)
            4'h0: nxt_sel = s0_s1[`ASQ_LO_MSB:`ASQ_LO_LSB];
            4'h1: nxt_sel = s0_s1[`ASQ_HI_MSB:`ASQ_HI_LSB];
            4'h2: nxt_sel = s2_s3[`ASQ_LO_MSB:`ASQ_LO_LSB];
            4'h3: nxt_sel = s2_s3[`ASQ_HI_MSB:`ASQ_HI_LSB];
            4'h4: nxt_sel = s4_s5[`ASQ_LO_MSB:`ASQ_LO_LSB];
            4'h5: nxt_sel = s4_s5[`ASQ_HI_MSB:`ASQ_HI_LSB];
            4'h6: nxt_sel = s6_s7[`ASQ_LO_MSB:`ASQ_LO_LSB];
            4'h7: nxt_sel = s6_s7[`ASQ_HI_MSB:`ASQ_HI_LSB];
            4'h8: nxt_sel = s8_s9[`ASQ_LO_MSB:`ASQ_LO_LSB];
            4'h9: nxt_sel = s8_s9[`ASQ_HI_MSB:`ASQ_HI_LSB];
            4'ha: nxt_sel = len_s10[`ASQ_LO_MSB:`ASQ_LO_LSB];
            default: nxt_sel = `ASQ_RST_NIB;
        endcase
    end

    // frame sequencing; the length is caught at each frame start so a
    // rewrite mid-frame never cuts the running frame short
    always @*
    begin
        nxt_state       = state_ff;
        nxt_slot        = slot_ff;
        nxt_len         = len_ff;
        nxt_slot_start  = 1'b0;
        nxt_frame_start = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_slot = `ASQ_RST_NIB;
                if (eff_len != `ASQ_RST_NIB)
                begin
                    nxt_state       = ST_RUN;
                    nxt_len         = eff_len;
                    nxt_slot_start  = 1'b1;
                    nxt_frame_start = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (slot_tick)
                begin
                    nxt_slot_start = 1'b1;
                    if (slot_ff == len_ff - `ASQ_SLOT_ONE)
                    begin
                        nxt_slot = `ASQ_RST_NIB;
                        nxt_len  = eff_len;
                        if (eff_len == `ASQ_RST_NIB)
                        begin
                            nxt_state      = ST_IDLE;
                            nxt_slot_start = 1'b0;
                        end
                        else
                        begin
                            nxt_frame_start = 1'b1;
                        end
                    end
                    else
                    begin
                        nxt_slot = slot_ff + `ASQ_SLOT_ONE;
                    end
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_slot  = `ASQ_RST_NIB;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @*
    begin
        nxt_rdata = `ASQ_RD_ZERO;
        if (rd_i)
        begin
            if (hit_len_s10)
                nxt_rdata = len_s10;
            else if (hit_s8_s9)
                nxt_rdata = s8_s9;
            else if (hit_s6_s7)
                nxt_rdata = s6_s7;
            else if (hit_s4_s5)
                nxt_rdata = s4_s5;
            else if (hit_s2_s3)
                nxt_rdata = s2_s3;
            else if (hit_s0_s1)
                nxt_rdata = s0_s1;
            else if (hit_status)
                nxt_rdata = {len_ff, slot_ff};
            else
                nxt_rdata = `ASQ_RD_ZERO;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff       <= ST_IDLE;
            slot_ff        <= `ASQ_RST_NIB;
            len_ff         <= `ASQ_RST_NIB;
            sel_ff         <= `ASQ_RST_NIB;
            slot_start_ff  <= 1'b0;
            frame_start_ff <= 1'b0;
            rdata_ff       <= `ASQ_RD_ZERO;
            busy_ff        <= 1'b0;
        end
        else
        begin
            state_ff       <= nxt_state;
            slot_ff        <= nxt_slot;
            len_ff         <= nxt_len;
            busy_ff        <= (nxt_state == ST_RUN);
            // selector is taken only at a slot start, held through the slot
            if (nxt_slot_start)
            begin
                sel_ff <= nxt_sel;
            end
            else if (nxt_state != ST_RUN)
            begin
                sel_ff <= `ASQ_RST_NIB;
            end
            slot_start_ff  <= nxt_slot_start;
            frame_start_ff <= nxt_frame_start;
            rdata_ff       <= nxt_rdata;
        end
    end

    assign rdata_o       = rdata_ff;
    assign mux_sel_o     = sel_ff;
    assign slot_o        = slot_ff;
    assign slot_start_o  = slot_start_ff;
    assign frame_start_o = frame_start_ff;
    assign busy_o        = busy_ff;

endmodule // asq_sequencer

`default_nettype wire

/* verif/asq_seq_monitor.sv */
// port assertions for the slot sequencer
`timescale 1ns/1ps
`default_nettype none
module asq_seq_monitor
(
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic [3:0]  mux_sel_o,
    input wire logic [3:0]  slot_o,
    input wire logic        slot_start_o,
    input wire logic        frame_start_o,
    input wire logic        busy_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_slot_end;
        ##200 (slot_start_o || !busy_o);
    endsequence
    sequence s_quiet;
        (!slot_start_o)[*8];
    endsequence
    chk_slot_limit: assert property (slot_o <= 4'ha)
        else $error("slot index above ten");
    chk_frame_begin: assert property (frame_start_o |->
        slot_start_o && slot_o == 4'h0) else $error("frame start slot");
    chk_wrap_zero: assert property (slot_start_o && slot_o == 4'h0
        |-> frame_start_o) else $error("slot zero without frame");
    chk_slot_step: assert property (slot_start_o && !frame_start_o
        |-> slot_o == $past(slot_o) + 4'h1) else $error("slot step");
    chk_slot_dwell: assert property (slot_start_o |-> s_slot_end)
        else $error("slot dwell");
    chk_pulse_gap: assert property (slot_start_o |=> s_quiet)
        else $error("slot pulse too close");
    chk_idle_quiet: assert property (!busy_o |-> slot_o == 4'h0
        && mux_sel_o == 4'h0 && !slot_start_o) else $error("idle outputs");
    chk_sel_hold: assert property (busy_o && !slot_start_o
        |-> $stable(mux_sel_o) && $stable(slot_o)) else $error("mid slot");
    chk_rd_window: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside window");
endmodule // asq_seq_monitor
bind asq_sequencer asq_seq_monitor i_mon (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .mux_sel_o(mux_sel_o), .slot_o(slot_o),
    .slot_start_o(slot_start_o), .frame_start_o(frame_start_o),
    .busy_o(busy_o));
`default_nettype wire

/* verif/asq_mux_model.sv */
// analog multiplexer model: records the input chosen for each slot
`timescale 1ns/1ps
`default_nettype none
module asq_mux_model
(
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    input wire logic [3:0] sel_i,
    input wire logic [3:0] slot_i,
    input wire logic       strobe_i
);
    logic [3:0] seen_ff [0:10];
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int k = 0; k < 11; k++) seen_ff[k] <= 4'h0;
        end
        else if (strobe_i && slot_i <= 4'ha)
        begin
            seen_ff[slot_i] <= sel_i;
        end
    end
endmodule // asq_mux_model
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the slot sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    wire  [7:0]  rdata_o;
    wire  [3:0]  mux_sel_o;
    wire  [3:0]  slot_o;
    wire         slot_start_o;
    wire         frame_start_o;
    wire         busy_o;
    int          bad_count = 0;
    int          n_compared = 0;
    int          n;

    asq_sequencer i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .mux_sel_o(mux_sel_o), .slot_o(slot_o),
        .slot_start_o(slot_start_o), .frame_start_o(frame_start_o),
        .busy_o(busy_o));
    asq_mux_model i_mux (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .sel_i(mux_sel_o), .slot_i(slot_o), .strobe_i(slot_start_o));

    initial
    begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task final_report;
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    task bus_rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask

    // slots in the next whole frame; a missing frame start is a failure
    task count_frame(output int cnt);
        int i;
        i = 0;
        cnt = 1;
        do begin @(posedge clk_sys_i); #1; i++; end
        while (frame_start_o !== 1'b1 && i < 3000);
        if (i >= 3000)
        begin
            bad_count++;
            final_report;
        end
        do begin
            @(posedge clk_sys_i);
            #1;
            i++;
            if (slot_start_o === 1'b1 && frame_start_o !== 1'b1) cnt++;
        end while (frame_start_o !== 1'b1 && i < 6000);
        if (i >= 6000)
        begin
            bad_count++;
            final_report;
        end
    endtask

    task t_reset_map;
        for (int k = 0; k < 6; k++) bus_rd(16'(16'h2100 + k), 8'h00);
        bus_wr(16'h2107, 8'h5a);
        bus_rd(16'h2107, 8'h00);
        `CHK(busy_o, 1'b0)
    endtask

    task t_slot_map;
        for (int k = 0; k < 5; k++)
            bus_wr(16'(16'h2105 - k), {4'(2 * k + 2), 4'(2 * k + 1)});
        bus_wr(16'h2100, 8'hbb);
        for (int k = 0; k < 5; k++)
            bus_rd(16'(16'h2105 - k), {4'(2 * k + 2), 4'(2 * k + 1)});
        count_frame(n);
        `CHK(n, 11)
        for (int s = 0; s < 11; s++)
            `CHK(i_mux.seen_ff[s], 4'(s + 1))
    endtask

    task t_len_clamp;
        bus_wr(16'h2100, 8'hfb);
        bus_rd(16'h2100, 8'hfb);
        count_frame(n);
        `CHK(n, 11)
        bus_wr(16'h2100, 8'h2b);
        count_frame(n);
        `CHK(n, 2)
        bus_rd(16'h2106, 8'h20);
    endtask

    task t_stop;
        int i;
        i = 0;
        bus_wr(16'h2100, 8'h00);
        while (busy_o !== 1'b0 && i < 3000)
        begin
            @(posedge clk_sys_i);
            #1;
            i++;
        end
        `CHK(busy_o, 1'b0)
        `CHK(slot_o, 4'h0)
        `CHK(mux_sel_o, 4'h0)
    endtask

    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset_map;
        t_slot_map;
        t_len_clamp;
        t_stop;
        final_report;
    end
endmodule // tb
`default_nettype wire
